/* File: rtl/hmc_consts.svh */
/*
 * constants for the health monitor command unit: task-file offsets,
 * field positions, command codes, reset values and timing counts.
 * assumes a 50 MHz clock and inclusion by bare name.
 */
`ifndef HMC_CONSTS_SVH
`define HMC_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------------
`define HMC_OFF_FEATURE    4'h1
`define HMC_OFF_ROUTINE    4'h3
`define HMC_OFF_SIG_MID    4'h4
`define HMC_OFF_SIG_HIGH   4'h5
`define HMC_OFF_UNIT       4'h6
`define HMC_OFF_OPCODE     4'h7
`define HMC_OFF_ERROR      4'h8
`define HMC_OFF_STATUS     4'h9
`define HMC_OFF_TEST_STAT  4'hA
`define HMC_OFF_CTRL       4'hB

// ----------------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------------
`define HMC_ST_BUSY        7
`define HMC_ST_READY       6
`define HMC_ST_FAULT       5
`define HMC_ST_DREQ        3
`define HMC_ST_ERR         0
`define HMC_ER_ID_NOT_FOUND_FLAG        4
`define HMC_ER_ABORT       2
`define HMC_DEV_SEL        4

// ----------------------------------------------------------------------
// command and signature codes
// ----------------------------------------------------------------------
`define HMC_OPC_MONITOR    8'hB0
`define HMC_FEAT_ENABLE    8'hD8
`define HMC_FEAT_EXECUTE   8'hD4
`define HMC_SIG_MID        8'h4F
`define HMC_SIG_HIGH       8'hC2
`define HMC_FAIL_MID       8'hF4
`define HMC_FAIL_HIGH      8'h2C
`define HMC_SUB_COLLECT    8'h00
`define HMC_SUB_SHORT_BG   8'h01
`define HMC_SUB_EXT_BG     8'h02
`define HMC_SUB_ABORT_BG   8'h7F
`define HMC_SUB_SHORT_FG   8'h81
`define HMC_SUB_EXT_FG     8'h82

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define HMC_STATUS_RST     8'h40
`define HMC_STATUS_LOAD    8'h80
`define HMC_SERVICE_MS     2000
`define HMC_CLK_KHZ        50000
`define HMC_SERVICE_CYC    (`HMC_SERVICE_MS * `HMC_CLK_KHZ)

`endif

/* File: rtl/hmc_pkg.sv */
/*
 * types for the health monitor command unit.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package hmc_pkg;
  // command engine states
  typedef enum logic [2:0] {
    HMC_IDLE,
    HMC_LOAD,
    HMC_DECODE,
    HMC_FG_RUN,
    HMC_DONE
  } hmc_state_t;

  // routine kinds decoded from routine_select
  typedef enum logic [2:0] {
    HMC_RT_NONE,
    HMC_RT_BG,
    HMC_RT_BG_STOP,
    HMC_RT_FG,
    HMC_RT_BAD
  } hmc_routine_t;
endpackage

/* File: rtl/hmc_routine_timer.sv */
/*
 * routine runner: counts a routine's duration and reports done.
 * assumes start is a one-cycle pulse and stop aborts at once.
 */
`timescale 1ns/10ps
`include "hmc_consts.svh"

module hmc_routine_timer #(
  parameter int CW = 24                  // counter width
) (
  input  wire logic          clock,      // 50 MHz clock
  input  wire logic          rst_n,      // sync reset, active low
  input  wire logic          start,      // start a routine
  input  wire logic          stop,       // abort running routine
  input  wire logic [CW-1:0] length,     // routine length in cycles
  output logic               running,    // routine in progress
  output logic               done        // pulse at natural end
);
  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  logic [CW-1:0] cnt_r;                  // cycles left
  logic          run_r;                  // running flag
  logic          done_r;                 // end pulse
  wire  logic    last = run_r && (cnt_r <= CW'(1)); // final cycle

  // restart wins over stop so a new routine replaces the old one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= last && !start && !stop;
      if (start) begin
        cnt_r <= length;
        run_r <= 1'b1;
      end else if (stop || last) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

  assign running = run_r;
  assign done    = done_r;
endmodule

/* File: rtl/hmc_command_unit.sv */
/*
 * health monitor command unit: decodes the monitor enable and the
 * immediate routine execute commands, runs routines and completes
 * with status, error and signature values.
 * assumes a host adapter on a plain register port, single clock,
 * and a non-volatile store that holds the enable flag outside.
 */
`timescale 1ns/10ps
`include "hmc_consts.svh"

// Functional notes
// - enable is B0h with D8h, 4Fh, C2h
// - enable success: ready set, others clear
// - bad enable values set abort flag
// - abort: busy, dreq clear, ready, err follows
// - may abort when action impossible
// - no monitoring before enable received
// - enable state kept in nonvolatile store
// - repeated enable changes nothing
// - device select bit returned on completion
// - execute is B0h with D4h, 4Fh, C2h
// - routine chosen from routine select value
// - foreground pass returns 4Fh and C2h
// - execute success: ready set, others clear
// - execute aborts if disabled or invalid
// - foreground fail returns F4h and 2Ch
// - foreground test failure sets abort flag
// - missing data sector sets id flag
// - foreground other abort returns 4Fh mid
// - routine codes 0,1,2,127,129,130 decoded
// - background runs after completion, no busy
// - foreground holds busy until result stored
// - new command stops background within limit
module hmc_command_unit #(
  parameter int TW        = 24,           // routine timer width
  parameter int SHORT_CYC = 1000,         // short test length
  parameter int EXT_CYC   = 10000,        // extended test length
  parameter int SERVICE_CYC = `HMC_SERVICE_CYC // background stop limit
) (
  input  wire logic       clock,          // 50 MHz clock
  input  wire logic       rst_n,          // sync reset, active low
  input  wire logic [3:0] reg_addr,       // register offset
  input  wire logic [7:0] reg_wdata,      // write data
  input  wire logic       reg_wr,         // write strobe
  input  wire logic       reg_rd,         // read strobe
  output logic      [7:0] reg_rdata,      // read data, next cycle
  input  wire logic       nv_valid,       // store has delivered flag
  input  wire logic       nv_enabled,     // stored enable flag
  output logic            nv_write,       // pulse: save enable flag
  output logic            nv_wdata,       // flag value to save
  input  wire logic       test_fail,      // routine saw a failure
  input  wire logic       sector_missing, // data sector id not found
  input  wire logic       dev_fault,      // device fault present
  output logic            monitor_on,     // monitoring active
  output logic            bg_running      // background routine busy
);
  // ----------------------------------------------------------------
  // task-file registers
  // ----------------------------------------------------------------
  logic [7:0] feature_r;                  // feature_select
  logic [7:0] routine_r;                  // routine_select
  logic [7:0] sig_mid_r;                  // signature_mid
  logic [7:0] sig_high_r;                 // signature_high
  logic [7:0] unit_r;                     // unit_select
  logic [7:0] error_r, error_nxt;         // error_flags
  logic [7:0] status_r, status_nxt;       // status_flags
  logic [7:0] test_stat_r;                // self-test result byte
  logic [7:0] rdata_r;                    // read data register
  logic       enabled_r;                  // monitoring enabled
  logic       loaded_r;                   // enable flag reloaded
  logic       fg_r;                       // foreground run active
  logic [7:0] opcode_r;                   // captured opcode
  hmc_pkg::hmc_state_t   state_r, state_nxt; // command state
  hmc_pkg::hmc_routine_t kind;            // decoded routine kind

  // ----------------------------------------------------------------
  // decode of host strobes
  // ----------------------------------------------------------------
  wire logic wr_op   = reg_wr && (reg_addr == `HMC_OFF_OPCODE);
  wire logic sig_ok  = (sig_mid_r == `HMC_SIG_MID) &&
                       (sig_high_r == `HMC_SIG_HIGH);
  wire logic is_mon  = (opcode_r == `HMC_OPC_MONITOR);
  wire logic is_en   = is_mon && sig_ok &&
                       (feature_r == `HMC_FEAT_ENABLE);
  wire logic is_ex   = is_mon && sig_ok &&
                       (feature_r == `HMC_FEAT_EXECUTE);
  // no opcode is taken until the stored flag is back
  wire logic take_op = wr_op && loaded_r &&
                       (state_r == hmc_pkg::HMC_IDLE);

  always_comb begin
    unique case (routine_r)
      `HMC_SUB_COLLECT, `HMC_SUB_SHORT_BG,
      `HMC_SUB_EXT_BG:   kind = hmc_pkg::HMC_RT_BG;
      `HMC_SUB_ABORT_BG: kind = hmc_pkg::HMC_RT_BG_STOP;
      `HMC_SUB_SHORT_FG,
      `HMC_SUB_EXT_FG:   kind = hmc_pkg::HMC_RT_FG;
      default:           kind = hmc_pkg::HMC_RT_BAD;
    endcase
  end

  // abort decided in the decode cycle
  wire logic ex_ok   = is_ex && enabled_r &&
                       (kind != hmc_pkg::HMC_RT_BAD);
  wire logic cmd_ok  = is_en || ex_ok;
  wire logic fg_req  = routine_r[7];      // foreground code family
  // foreground code refused for a reason other than failure
  wire logic fg_refused = is_mon && fg_req && !ex_ok &&
                          (feature_r == `HMC_FEAT_EXECUTE);
  wire logic start_bg = (state_r == hmc_pkg::HMC_DECODE) && ex_ok &&
                        (kind == hmc_pkg::HMC_RT_BG);
  wire logic start_fg = (state_r == hmc_pkg::HMC_DECODE) && ex_ok &&
                        (kind == hmc_pkg::HMC_RT_FG);
  wire logic ext_sel  = routine_r[1];     // extended variant
  wire logic [TW-1:0] run_len = ext_sel ? TW'(EXT_CYC) :
                                          TW'(SHORT_CYC);

  // ----------------------------------------------------------------
  // routine timer
  // ----------------------------------------------------------------
  logic run_busy;                         // timer running
  logic run_done;                         // timer finished
  // any new command stops a background routine
  wire logic stop_run = (take_op && !fg_r) ||
                        ((state_r == hmc_pkg::HMC_DECODE) &&
                         (kind == hmc_pkg::HMC_RT_BG_STOP) && ex_ok);

  hmc_routine_timer #(.CW(TW)) u_timer (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (start_bg || start_fg),
    .stop    (stop_run),
    .length  (run_len),
    .running (run_busy),
    .done    (run_done)
  );

  // ----------------------------------------------------------------
  // command state machine
  // ----------------------------------------------------------------
  // load cycle lets the opcode register settle before decode
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      hmc_pkg::HMC_IDLE:   if (take_op) state_nxt = hmc_pkg::HMC_LOAD;
      hmc_pkg::HMC_LOAD:   state_nxt = hmc_pkg::HMC_DECODE;
      hmc_pkg::HMC_DECODE: state_nxt = start_fg ? hmc_pkg::HMC_FG_RUN
                                                : hmc_pkg::HMC_DONE;
      hmc_pkg::HMC_FG_RUN: if (run_done) state_nxt = hmc_pkg::HMC_DONE;
      hmc_pkg::HMC_DONE:   state_nxt = hmc_pkg::HMC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // completion values
  // ----------------------------------------------------------------
  wire logic fg_fail = fg_r && run_done && test_fail;
  wire logic [7:0] err_done = {3'b000, sector_missing, 1'b0,
                               !cmd_ok, 2'b00};

  always_comb begin
    status_nxt = status_r;
    error_nxt  = error_r;
    if (take_op) begin
      status_nxt = 8'h80;                 // busy raised on opcode write
    end else if (state_r == hmc_pkg::HMC_DECODE && !start_fg) begin
      // id flag raised with the completion
      error_nxt  = is_ex ? err_done : {5'b0_0000, !cmd_ok, 2'b00};
      status_nxt = {1'b0, 1'b1, dev_fault && (error_nxt != 8'h00),
                    4'b0000, error_nxt != 8'h00};
      status_nxt[`HMC_ST_FAULT] = dev_fault && !cmd_ok;
    end else if (state_r == hmc_pkg::HMC_FG_RUN && run_done) begin
      error_nxt  = {3'b000, sector_missing, 1'b0, test_fail, 2'b00};
      status_nxt = {1'b0, 1'b1, dev_fault && test_fail, 4'b0000,
                    error_nxt != 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // register writes and completion
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      feature_r  <= 8'h00;
      routine_r  <= 8'h00;
      sig_mid_r  <= 8'h00;
      sig_high_r <= 8'h00;
      unit_r     <= 8'h00;
      opcode_r   <= 8'h00;
      error_r    <= 8'h00;
      status_r   <= `HMC_STATUS_LOAD;
      test_stat_r <= 8'h00;
      state_r    <= hmc_pkg::HMC_IDLE;
      fg_r       <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      status_r <= status_nxt;
      error_r  <= error_nxt;
      // busy until the flag is back, then plain ready
      if (!loaded_r) begin
        status_r <= nv_valid ? `HMC_STATUS_RST : `HMC_STATUS_LOAD;
      end
      if (reg_wr && state_r == hmc_pkg::HMC_IDLE) begin
        unique case (reg_addr)
          `HMC_OFF_FEATURE:  feature_r  <= reg_wdata;
          `HMC_OFF_ROUTINE:  routine_r  <= reg_wdata;
          `HMC_OFF_SIG_MID:  sig_mid_r  <= reg_wdata;
          `HMC_OFF_SIG_HIGH: sig_high_r <= reg_wdata;
          `HMC_OFF_UNIT:     unit_r     <= reg_wdata;
          `HMC_OFF_OPCODE:   opcode_r   <= reg_wdata;
          default: ;
        endcase
      end
      if (start_fg) begin
        fg_r <= 1'b1;
      end
      if (state_r == hmc_pkg::HMC_FG_RUN && run_done) begin
        fg_r        <= 1'b0;
        test_stat_r <= {7'h00, test_fail};
        sig_mid_r   <= fg_fail ? `HMC_FAIL_MID  : `HMC_SIG_MID;
        sig_high_r  <= fg_fail ? `HMC_FAIL_HIGH : `HMC_SIG_HIGH;
      end
      if (state_r == hmc_pkg::HMC_DECODE && fg_refused) begin
        sig_mid_r  <= `HMC_SIG_MID;
        sig_high_r <= `HMC_SIG_HIGH;
      end
    end
  end

  // ----------------------------------------------------------------
  // enable flag and non-volatile store
  // ----------------------------------------------------------------
  // reload once, save on change
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enabled_r <= 1'b0;
      loaded_r  <= 1'b0;
      nv_write  <= 1'b0;
      nv_wdata  <= 1'b0;
    end else begin
      nv_write <= 1'b0;
      if (!loaded_r && nv_valid) begin
        loaded_r  <= 1'b1;
        enabled_r <= nv_enabled;
      end
      if (state_r == hmc_pkg::HMC_DECODE && is_en && !enabled_r) begin
        enabled_r <= 1'b1;
        nv_write  <= 1'b1;
        nv_wdata  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // device select bit read back from unit register
  wire logic [7:0] unit_rd = {3'b000, unit_r[`HMC_DEV_SEL], 4'h0};
  wire logic [7:0] rd_mux =
    (reg_addr == `HMC_OFF_ROUTINE)   ? routine_r  :
    (reg_addr == `HMC_OFF_SIG_MID)   ? sig_mid_r  :
    (reg_addr == `HMC_OFF_SIG_HIGH)  ? sig_high_r :
    (reg_addr == `HMC_OFF_UNIT)      ? unit_rd    :
    (reg_addr == `HMC_OFF_ERROR)     ? error_r    :
    (reg_addr == `HMC_OFF_STATUS)    ? status_r   :
    (reg_addr == `HMC_OFF_TEST_STAT) ? test_stat_r :
    (reg_addr == `HMC_OFF_CTRL)      ? {6'h00, run_busy, enabled_r} :
                                       8'h00;

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata  = rdata_r;
  assign monitor_on = enabled_r && loaded_r;
  assign bg_running = run_busy && !fg_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // helper terms sampled by the checks below
  wire logic en_decode = (state_r == hmc_pkg::HMC_DECODE) && is_en;
  wire logic reload_on = !loaded_r && nv_valid && nv_enabled;

  a_fg_busy_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    fg_r |-> status_r[`HMC_ST_BUSY])
    else $error("busy dropped during foreground routine");
  a_bg_no_busy: assert property (
    @(posedge clock) disable iff (!rst_n)
    bg_running && state_r == hmc_pkg::HMC_IDLE && loaded_r
    |-> !status_r[`HMC_ST_BUSY])
    else $error("busy raised during background routine");
  a_enable_done: assert property (
    @(posedge clock) disable iff (!rst_n)
    en_decode && loaded_r
    |=> status_r == 8'h40 && error_r == 8'h00)
    else $error("enable did not complete cleanly");
  a_bad_abort: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_r == hmc_pkg::HMC_DECODE && !cmd_ok && loaded_r
    |=> error_r[`HMC_ER_ABORT] && status_r[`HMC_ST_ERR]
        && status_r[`HMC_ST_READY])
    else $error("invalid command not aborted");
  a_exec_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_r == hmc_pkg::HMC_DECODE && is_ex && !enabled_r
    |=> error_r[`HMC_ER_ABORT])
    else $error("execute accepted while disabled");
  a_fail_sig: assert property (
    @(posedge clock) disable iff (!rst_n)
    fg_fail |=> sig_mid_r == 8'hF4 && sig_high_r == 8'h2C
        && error_r[`HMC_ER_ABORT])
    else $error("foreground failure signature wrong");
  a_enable_sticky: assert property (
    @(posedge clock) disable iff (!rst_n)
    enabled_r && loaded_r |=> enabled_r)
    else $error("enable flag lost");
  a_mon_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(monitor_on) |-> $past(en_decode) || $past(reload_on))
    else $error("monitoring started without enable");
  a_first_save: assert property (
    @(posedge clock) disable iff (!rst_n)
    en_decode && !enabled_r |=> nv_write && nv_wdata)
    else $error("first enable not saved");
  a_repeat_quiet: assert property (
    @(posedge clock) disable iff (!rst_n)
    en_decode && enabled_r |=> !nv_write && enabled_r)
    else $error("repeated enable disturbed the stored flag");
  a_bg_stop: assert property (
    @(posedge clock) disable iff (!rst_n)
    take_op && bg_running |=> !bg_running)
    else $error("background routine not stopped by new command");
  a_fg_refused: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_r == hmc_pkg::HMC_DECODE && fg_refused
    |=> sig_mid_r == `HMC_SIG_MID)
    else $error("refused foreground request lost signature");
  a_reload_busy: assert property (
    @(posedge clock) disable iff (!rst_n)
    !loaded_r |-> status_r[`HMC_ST_BUSY] && !take_op)
    else $error("ready shown before enable flag reload");
endmodule

/* File: tb/hmc_nv_store.sv */
/*
 * non-volatile store model holding the monitoring enable flag.
 * assumes the command unit pulses nv_write and reads nv_enabled only
 * while nv_valid is high; the flag itself ignores rst_n.
 */
`timescale 1ns/10ps

module hmc_nv_store #(
  parameter int DLY = 10                 // reload latency in cycles
) (
  input  wire logic clock,               // 50 MHz clock
  input  wire logic rst_n,               // sync reset, active low
  input  wire logic nv_write,            // save request
  input  wire logic nv_wdata,            // value to save
  output logic      nv_valid,            // flag presented
  output logic      nv_enabled,          // stored flag
  output logic      flag                 // stored flag, for the bench
);
  int cnt;                               // cycles since reset release

  initial flag = 1'b0;                   // factory state: disabled
  initial nv_valid = 1'b0;

  // ----------------------------------------------------------------
  // reload after reset, keep flag across resets
  // ----------------------------------------------------------------
  // flag survives reset
  always @(posedge clock) begin
    if (!rst_n) begin
      cnt <= 0;
      nv_valid <= 1'b0;
    end else begin
      if (cnt < DLY) cnt <= cnt + 1;
      nv_valid <= (cnt == DLY) || nv_valid;
    end
    if (nv_write) flag <= nv_wdata;
  end

  // not presented: inverse value, so a premature read shows up
  assign nv_enabled = nv_valid ? flag : ~flag;
endmodule

/* File: tb/tb_top.sv */
/*
 * self-checking bench for the health monitor command unit.
 * assumes the register offsets and codes of hmc_consts.svh.
 */
`timescale 1ns/10ps
`include "hmc_consts.svh"
`define CHK(nm,e,g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb_top;
  logic       clock, rst_n, reg_wr, reg_rd, nv_valid, nv_enabled;
  logic       nv_write, nv_wdata, test_fail, sector_missing, dev_fault;
  logic       monitor_on, bg_running, nv_flag;
  logic [3:0] reg_addr;                  // register offset
  logic [7:0] reg_wdata, reg_rdata, d, s0;
  int         errors, checks, cycles, nv_writes, i;
  typedef struct {logic [7:0] f, s, m, h, st, er;} hmc_row_t;
  // feature, routine, mid, high, expected status, expected error
  hmc_row_t rows[10] = '{
    '{8'hD8, 8'h00, 8'h4F, 8'hC2, 8'h40, 8'h00},
    '{8'hD9, 8'h00, 8'h4F, 8'hC2, 8'h41, 8'h04},
    '{8'hD8, 8'h00, 8'h4E, 8'hC2, 8'h41, 8'h04},
    '{8'hD4, 8'h00, 8'h4F, 8'hC3, 8'h41, 8'h04},
    '{8'hD4, 8'h00, 8'h4F, 8'hC2, 8'h40, 8'h00},
    '{8'hD4, 8'h01, 8'h4F, 8'hC2, 8'h40, 8'h00},
    '{8'hD4, 8'h7F, 8'h4F, 8'hC2, 8'h40, 8'h00},
    '{8'hD4, 8'h03, 8'h4F, 8'hC2, 8'h41, 8'h04},
    '{8'hD4, 8'hC0, 8'h4F, 8'hC2, 8'h41, 8'h04},
    '{8'hD4, 8'h80, 8'h4F, 8'hC2, 8'h41, 8'h04}};

  hmc_command_unit #(.SHORT_CYC(20), .EXT_CYC(40)) i_hmc_command_unit (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .nv_valid(nv_valid), .nv_enabled(nv_enabled),
    .nv_write(nv_write), .nv_wdata(nv_wdata), .test_fail(test_fail),
    .sector_missing(sector_missing), .dev_fault(dev_fault),
    .monitor_on(monitor_on), .bg_running(bg_running));
  hmc_nv_store i_hmc_nv_store (.clock(clock), .rst_n(rst_n),
    .nv_write(nv_write), .nv_wdata(nv_wdata), .nv_valid(nv_valid),
    .nv_enabled(nv_enabled), .flag(nv_flag));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // cycle ceiling and save pulse count
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (nv_write === 1'b1) nv_writes++;
    if (cycles == 20000) begin
      errors++;
      print_verdict;
    end
  end

  task print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // full task-file load, then poll status until busy drops
  task cmd(input logic [7:0] f, s, m, h);
    wr(`HMC_OFF_FEATURE, f); wr(`HMC_OFF_ROUTINE, s);
    wr(`HMC_OFF_SIG_MID, m); wr(`HMC_OFF_SIG_HIGH, h);
    wr(`HMC_OFF_UNIT, 8'h10); wr(`HMC_OFF_OPCODE, `HMC_OPC_MONITOR);
    rd(`HMC_OFF_STATUS, s0);              // still the value before decode
    rd(`HMC_OFF_STATUS, s0);              // first value after decode
    d = s0;
    repeat (100) if (d[7] === 1'b1) rd(`HMC_OFF_STATUS, d);
  endtask

  task chk_done(input logic [7:0] st, er);
    `CHK("status", st, d)
    rd(`HMC_OFF_ERROR, d);
    `CHK("error", er, d)
  endtask

  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 8'h00; test_fail = 1'b0; sector_missing = 1'b0;
    dev_fault = 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    // an opcode this early must be ignored while the flag reloads
    wr(`HMC_OFF_OPCODE, `HMC_OPC_MONITOR);
    rd(`HMC_OFF_STATUS, d);
    `CHK("reset status", `HMC_STATUS_LOAD, d)
    repeat (20) @(posedge clock);
    rd(`HMC_OFF_STATUS, d);
    `CHK("ready status", `HMC_STATUS_RST, d)
    rd(`HMC_OFF_ERROR, d);
    `CHK("early opcode", 8'h00, d)
    cmd(8'hD4, 8'h81, 8'h4F, 8'hC2);
    chk_done(8'h41, 8'h04);
    `CHK("monitor off", 1'b0, monitor_on)
    cmd(8'hD8, 8'h00, 8'h4F, 8'hC2);
    chk_done(8'h40, 8'h00);
    `CHK("stored flag", 1'b1, nv_flag)
    for (i = 0; i < 10; i++) begin
      cmd(rows[i].f, rows[i].s, rows[i].m, rows[i].h);
      chk_done(rows[i].st, rows[i].er);
    end
    `CHK("save count", 1, nv_writes)
    rd(`HMC_OFF_UNIT, d);
    `CHK("unit", 8'h10, d)
    rd(4'hF, d);
    `CHK("unmapped", 8'h00, d)
    // long background routine, stopped by the opcode write of the code 127 command well before its end
    cmd(8'hD4, 8'h02, 8'h4F, 8'hC2);
    `CHK("bg no busy", 8'h40, s0)
    `CHK("bg running", 1'b1, bg_running)
    rd(`HMC_OFF_CTRL, d);
    `CHK("ctrl", 8'h03, d)
    cmd(8'hD4, 8'h7F, 8'h4F, 8'hC2);
    `CHK("bg stopped", 1'b0, bg_running)
    // foreground short and extended, pass then fail
    for (i = 0; i < 4; i++) begin
      test_fail <= i[1];
      cmd(8'hD4, 8'h81 + i[0], 8'h4F, 8'hC2);
      `CHK("fg busy", 8'h80, s0)
      chk_done(i[1] ? 8'h41 : 8'h40, i[1] ? 8'h04 : 8'h00);
      rd(`HMC_OFF_SIG_MID, d);
      `CHK("mid", i[1] ? `HMC_FAIL_MID : `HMC_SIG_MID, d)
      rd(`HMC_OFF_SIG_HIGH, d);
      `CHK("high", i[1] ? `HMC_FAIL_HIGH : `HMC_SIG_HIGH, d)
      rd(`HMC_OFF_TEST_STAT, d);
      `CHK("test result", i[1], d[0])
    end
    test_fail <= 1'b0;
    dev_fault <= 1'b1;
    cmd(8'hD4, 8'h81, 8'h4E, 8'hC2);
    chk_done(8'h61, 8'h04);
    rd(`HMC_OFF_SIG_MID, d);
    `CHK("mid other abort", 8'h4F, d)
    dev_fault <= 1'b0;
    sector_missing <= 1'b1;
    cmd(8'hD4, 8'h00, 8'h4F, 8'hC2);
    `CHK("err summary", 1'b1, d[0])
    rd(`HMC_OFF_ERROR, d);
    `CHK("id flag", 1'b1, d[4])
    sector_missing <= 1'b0;
    // second reset: enable must come back from the store
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (20) @(posedge clock);
    `CHK("reloaded", 1'b1, monitor_on)
    cmd(8'hD4, 8'h00, 8'h4F, 8'hC2);
    chk_done(8'h40, 8'h00);
    print_verdict;
  end
endmodule
